// >>> verilog/tmr_pkg.sv
package tmr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_SETUP = 8'h00;
  localparam logic [7:0] ADDR_TICK_COUNT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SETUP_SOURCE_BIT = 5;
  localparam int SETUP_EDGE_BIT = 4;
  localparam int SETUP_OWNER_BIT = 3;
  localparam int SETUP_RATE_LSB = 0;
  localparam int IRQC_ENABLE_BIT = 5;
  localparam int IRQC_FLAG_BIT = 2;
  localparam int STAT_OVERFLOW_BIT = 0;
  localparam int STAT_PIN_EDGE_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_SETUP_RESET = 8'hff;
  localparam logic [7:0] PORT_A_DIRECTION_RESET = 8'hff;
  localparam logic [7:0] TICK_COUNT_RESET = 8'h00;
  localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
  localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tmr_pkg

// >>> verilog/tmr_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_prescaler (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic event_i,
  input wire logic clear_i,
  input wire logic hold_i,
  input wire logic [2:0] rate_i,
  output logic timer_level_o,
  output logic wdt_wrap_o
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] low_mask;

  // ----------------------------------------------------------------
  // Divider: cnt[rate] rises every 2^(rate+1) events
  // ----------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    if (clear_i) begin
      next_cnt = 8'h00;
    end else if (event_i && !hold_i) begin
      next_cnt = cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign low_mask = 8'((9'h001 << rate_i) - 9'h001);
  assign timer_level_o = cnt[rate_i];
  // Watchdog ratio is 2^rate, so rate 0 passes every event
  assign wdt_wrap_o = event_i && !hold_i && !clear_i
                      && ((cnt & low_mask) == low_mask);

endmodule : tmr_prescaler
`default_nettype wire

// >>> verilog/tmr_phase_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_phase_sync (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic level_i,
  output logic cycle_end_o,
  output logic rise_o
);

  logic [1:0] phase;
  logic [1:0] next_phase;
  logic samp_q2;
  logic next_samp_q2;
  logic samp_q4;
  logic next_samp_q4;
  logic samp_q4_d;
  logic next_samp_q4_d;

  // ----------------------------------------------------------------
  // Four phases per instruction cycle; sample on Q2 then Q4
  // ----------------------------------------------------------------
  always_comb begin
    next_phase = phase + 2'h1;
    next_samp_q2 = (phase == tmr_pkg::PHASE_Q2) ? level_i : samp_q2;
    next_samp_q4 = (phase == tmr_pkg::PHASE_Q4) ? samp_q2 : samp_q4;
    next_samp_q4_d = (phase == tmr_pkg::PHASE_Q4) ? samp_q4 : samp_q4_d;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      phase <= 2'h0;
      // Start high: a level that is already high at reset is no edge
      samp_q2 <= 1'b1;
      samp_q4 <= 1'b1;
      samp_q4_d <= 1'b1;
    end else begin
      phase <= next_phase;
      samp_q2 <= next_samp_q2;
      samp_q4 <= next_samp_q4;
      samp_q4_d <= next_samp_q4_d;
    end
  end

  assign cycle_end_o = (phase == tmr_pkg::PHASE_Q4);
  // One pulse per synchronised rise, at the end of the cycle after Q4 sample
  assign rise_o = cycle_end_o && samp_q4 && !samp_q4_d;

endmodule : tmr_phase_sync
`default_nettype wire

// >>> verilog/tmr_timer_top.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_timer_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic count_input_pin_i,
  input wire logic sleep_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic wdt_base_tick_i,
  output logic wdt_tick_o,
  output logic timer_irq_o,
  output logic irq_o,
  output logic [7:0] port_a_direction_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] timer_setup, next_timer_setup;
  logic [7:0] tick_count, next_tick_count;
  logic [7:0] irq_control, next_irq_control;
  logic [7:0] port_a_direction, next_port_a_direction;
  logic [1:0] irq_status, next_irq_status;
  logic [1:0] irq_mask, next_irq_mask;
  logic [1:0] inhibit, next_inhibit;
  logic pin_d, next_pin_d;
  logic wdt_tick, next_wdt_tick;

  // Bus state
  logic aw_full, next_aw_full;
  logic w_full, next_w_full;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;

  // ----------------------------------------------------------------
  // Timer datapath
  // ----------------------------------------------------------------
  logic source_ext;
  logic edge_fall;
  logic owner_wdt;
  logic [2:0] rate;
  logic pin_level;
  logic pin_event;
  logic cycle_end;
  logic synced_rise;
  logic step_src;
  logic pre_event;
  logic pre_clear;
  logic pre_level;
  logic wdt_wrap;
  logic bypass_level;
  logic count_level;
  logic do_write;
  logic wr_setup, wr_count, wr_irqc, wr_porta, wr_status, wr_mask;
  logic count_step;
  logic overflow;

  assign source_ext = timer_setup[tmr_pkg::SETUP_SOURCE_BIT];
  assign edge_fall = timer_setup[tmr_pkg::SETUP_EDGE_BIT];
  assign owner_wdt = timer_setup[tmr_pkg::SETUP_OWNER_BIT];
  assign rate = timer_setup[tmr_pkg::SETUP_RATE_LSB +: 3];

  // Inverting for falling edges turns every selected edge into a rise
  assign pin_level = count_input_pin_i ^ edge_fall;
  assign pin_event = pin_level && !(pin_d ^ edge_fall);

  // Prescaler input follows its owner
  assign pre_event = owner_wdt ? wdt_base_tick_i
                   : (source_ext ? pin_event : cycle_end);
  assign pre_clear = owner_wdt ? watchdog_clear_instr_i
                   : wr_count;

  // Without prescaler the pin level goes straight to the synchroniser
  assign bypass_level = pin_level;
  assign count_level = owner_wdt ? bypass_level : pre_level;
  // A level cannot rise every cycle, so timer mode without prescaler steps on the cycle end itself
  assign step_src = (owner_wdt && !source_ext) ? cycle_end : synced_rise;

  tmr_prescaler u_prescaler (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .event_i(pre_event),
    .clear_i(pre_clear),
    .hold_i(sleep_i),
    .rate_i(rate),
    .timer_level_o(pre_level),
    .wdt_wrap_o(wdt_wrap)
  );

  tmr_phase_sync u_phase_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .level_i(count_level),
    .cycle_end_o(cycle_end),
    .rise_o(synced_rise)
  );

  // Sleep blocks the step, so the count cannot wrap and wake anything
  assign count_step = step_src && !sleep_i && (inhibit == 2'h0);
  assign overflow = count_step && (tick_count == tmr_pkg::COUNT_MAX);

  // ----------------------------------------------------------------
  // AXI4-Lite write decode
  // ----------------------------------------------------------------
  assign do_write = aw_full && w_full && !bvalid && w_strb[0];
  assign wr_setup = do_write && (aw_addr == tmr_pkg::ADDR_TIMER_SETUP);
  assign wr_count = do_write && (aw_addr == tmr_pkg::ADDR_TICK_COUNT);
  assign wr_irqc = do_write && (aw_addr == tmr_pkg::ADDR_IRQ_CONTROL);
  assign wr_porta = do_write && (aw_addr == tmr_pkg::ADDR_PORT_A_DIRECTION);
  assign wr_status = do_write && (aw_addr == tmr_pkg::ADDR_IRQ_STATUS);
  assign wr_mask = do_write && (aw_addr == tmr_pkg::ADDR_IRQ_MASK);

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == tmr_pkg::ADDR_TIMER_SETUP) || (a == tmr_pkg::ADDR_TICK_COUNT)
           || (a == tmr_pkg::ADDR_IRQ_CONTROL) || (a == tmr_pkg::ADDR_PORT_A_DIRECTION)
           || (a == tmr_pkg::ADDR_IRQ_STATUS) || (a == tmr_pkg::ADDR_IRQ_MASK);
  endfunction : addr_ok

  // ----------------------------------------------------------------
  // Timer and register next state
  // ----------------------------------------------------------------
  always_comb begin
    next_timer_setup = wr_setup ? w_data[7:0] : timer_setup;
    next_port_a_direction = wr_porta ? w_data[7:0] : port_a_direction;
    next_irq_mask = wr_mask ? w_data[1:0] : irq_mask;
    next_pin_d = count_input_pin_i;
    next_wdt_tick = owner_wdt && wdt_wrap;

    next_tick_count = tick_count;
    next_inhibit = inhibit;
    if (wr_count) begin
      next_tick_count = w_data[7:0];
      next_inhibit = tmr_pkg::WRITE_INHIBIT_CYCLES;
    end else begin
      if (count_step) begin
        next_tick_count = tick_count + 8'h01;
      end
      if (cycle_end && (inhibit != 2'h0)) begin
        next_inhibit = inhibit - 2'h1;
      end
    end

    next_irq_control = irq_control;
    if (wr_irqc) begin
      next_irq_control = w_data[7:0];
    end
    if (overflow) begin
      next_irq_control[tmr_pkg::IRQC_FLAG_BIT] = 1'b1;
    end

    // Sticky events, write one to clear; a new event wins over the clear
    next_irq_status = irq_status;
    if (wr_status) begin
      next_irq_status = irq_status & ~w_data[1:0];
    end
    if (overflow) begin
      next_irq_status[tmr_pkg::STAT_OVERFLOW_BIT] = 1'b1;
    end
    if (pin_event) begin
      next_irq_status[tmr_pkg::STAT_PIN_EDGE_BIT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus next state
  // ----------------------------------------------------------------
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = {s_axi_awaddr[7:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_full && w_full && !bvalid) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_ok(aw_addr) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = tmr_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'h0})
        tmr_pkg::ADDR_TIMER_SETUP: next_rdata[7:0] = timer_setup;
        tmr_pkg::ADDR_TICK_COUNT: next_rdata[7:0] = tick_count;
        tmr_pkg::ADDR_IRQ_CONTROL: next_rdata[7:0] = irq_control;
        tmr_pkg::ADDR_PORT_A_DIRECTION: next_rdata[7:0] = port_a_direction;
        tmr_pkg::ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
        tmr_pkg::ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
        default: next_rresp = tmr_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      timer_setup <= tmr_pkg::TIMER_SETUP_RESET;
      tick_count <= tmr_pkg::TICK_COUNT_RESET;
      irq_control <= tmr_pkg::IRQ_CONTROL_RESET;
      port_a_direction <= tmr_pkg::PORT_A_DIRECTION_RESET;
      irq_status <= tmr_pkg::IRQ_STATUS_RESET;
      irq_mask <= tmr_pkg::IRQ_MASK_RESET;
      inhibit <= 2'h0;
      pin_d <= 1'b0;
      wdt_tick <= 1'b0;
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
    end else begin
      timer_setup <= next_timer_setup;
      tick_count <= next_tick_count;
      irq_control <= next_irq_control;
      port_a_direction <= next_port_a_direction;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      inhibit <= next_inhibit;
      pin_d <= next_pin_d;
      wdt_tick <= next_wdt_tick;
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  // Only one read outstanding; next address waits for the answer to drain
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign timer_irq_o = irq_control[tmr_pkg::IRQC_FLAG_BIT]
                       && irq_control[tmr_pkg::IRQC_ENABLE_BIT];
  assign irq_o = |(irq_status & irq_mask);
  assign wdt_tick_o = wdt_tick;
  assign port_a_direction_o = port_a_direction;

endmodule : tmr_timer_top
`default_nettype wire

// >>> verification/tmr_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module tmr_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bready,
  input wire logic sleep_i,
  input wire logic wdt_tick_o,
  input wire logic timer_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] aw_q, next_aw_q;
  logic [1:0] wo_q, next_wo_q;
  logic own_q, next_own_q;
  logic bv_q;
  // Shadow of the owner bit, so tick pulses can be tied to the setup
  always_comb begin
    next_aw_q = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_q;
    next_wo_q = (s_axi_wvalid && s_axi_wready) ? {s_axi_wstrb[0], s_axi_wdata[3]} : wo_q;
    next_own_q = own_q;
    if (s_axi_bvalid && !bv_q && aw_q[7:2] == 6'h00 && wo_q[1]) begin
      next_own_q = wo_q[0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      aw_q <= 8'h00;
      wo_q <= 2'h0;
      own_q <= 1'b1;
      bv_q <= 1'b0;
    end else begin
      aw_q <= next_aw_q;
      wo_q <= next_wo_q;
      own_q <= next_own_q;
      bv_q <= s_axi_bvalid;
    end
  end
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_unmapped_err: assert property (s_axi_bvalid && !bv_q
    |-> s_axi_bresp == ((aw_q > 8'h17) ? tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY))
    else $error("wrong write response");
  a_flag_sw_clear: assert property ($fell(timer_irq_o) |-> s_axi_bvalid && !bv_q)
    else $error("timer request fell without a write");
  a_sleep_frozen: assert property ($past(sleep_i) && !(s_axi_bvalid && !bv_q) |-> !$rose(timer_irq_o))
    else $error("timer request rose in sleep");
  a_wdt_owner: assert property (wdt_tick_o |-> own_q || $past(own_q))
    else $error("watchdog tick while timer owns prescaler");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == tmr_pkg::RESP_SLVERR);
  c_irq: cover property ($rose(timer_irq_o));
  c_tick: cover property (wdt_tick_o);
endmodule : tmr_chk
bind tmr_timer_top tmr_chk tmr_chk_inst (.clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bready, .sleep_i, .wdt_tick_o, .timer_irq_o);
`default_nettype wire

// >>> verification/count_pulser.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// External count pulse source
// ------------------------------------------------------------
module count_pulser #(
  parameter int HOLD = 8
) (
  input wire logic clk_i,
  input wire logic idle_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  output logic pin_o,
  output logic busy_o
);
  int cnt;
  int left;
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
  end
  // Every level stands HOLD clocks, over one instruction cycle, so Q2 and Q4 both see it
  always @(posedge clk_i) begin
    if (!busy_o) begin
      pin_o <= idle_i;
      cnt <= 0;
      left <= 2 * n_i;
      busy_o <= go_i;
    end else if (cnt < HOLD - 1) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
      pin_o <= ~pin_o;
      left <= left - 1;
      busy_o <= (left > 1);
    end
  end
endmodule : count_pulser
`default_nettype wire

// >>> verification/test_eight_bit_timer_shared_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module test_eight_bit_timer_shared_prescaler;
  logic clk_i, rstn_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, go, pidle, pbusy;
  logic count_input_pin_i, sleep_i, watchdog_clear_instr_i, wdt_base_tick_i;
  logic wdt_tick_o, timer_irq_o, irq_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port_a_direction_o, pn;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int err_count, compares, cyc, nwt, s;
  tmr_timer_top tmr_timer_top_inst (.*);
  count_pulser #(.HOLD(8)) count_pulser_inst (.clk_i, .idle_i(pidle), .go_i(go), .n_i(pn),
    .pin_o(count_input_pin_i), .busy_o(pbusy));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (wdt_tick_o === 1'b1) nwt <= nwt + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("ERROR timeout expected done seen hang");
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] lo, input logic [31:0] hi,
    input logic [31:0] g);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count++;
      $display("ERROR %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd
  task automatic rck(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    rd(a);
    chk("rresp", 32'h0, 32'h0, 32'(resp));
    chk($sformatf("reg %h", a), lo, hi, rdv);
  endtask : rck
  task automatic wclr();
    watchdog_clear_instr_i <= 1'b1;
    @(posedge clk_i);
    watchdog_clear_instr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wclr
  task automatic bt(input int n);
    repeat (n) begin
      wdt_base_tick_i <= 1'b1;
      @(posedge clk_i);
      wdt_base_tick_i <= 1'b0;
      tk(3);
    end
  endtask : bt
  task automatic pg(input logic [7:0] n);
    pn <= n;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    tk(2);
    while (pbusy) @(posedge clk_i);
  endtask : pg
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sleep_i, go, pidle, rstn_i} = '0;
    {watchdog_clear_instr_i, wdt_base_tick_i} = '0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    pn = 8'h01;
    tk(10);
    rstn_i <= 1'b1;
    tk(1);
    rck(tmr_pkg::ADDR_TIMER_SETUP, 32'hff, 32'hff);
    rck(tmr_pkg::ADDR_TICK_COUNT, 32'h0, 32'h0);
    rck(tmr_pkg::ADDR_IRQ_CONTROL, 32'h0, 32'h0);
    rck(tmr_pkg::ADDR_PORT_A_DIRECTION, 32'hff, 32'hff);
    s_axi_bready <= 1'b0;
    wr(tmr_pkg::ADDR_PORT_A_DIRECTION, 8'h5a);
    tk(2);
    s_axi_bready <= 1'b1;
    tk(1);
    chk("port_a_direction_o", 32'h5a, 32'h5a, 32'(port_a_direction_o));
    s_axi_rready <= 1'b0;
    rck(tmr_pkg::ADDR_PORT_A_DIRECTION, 32'h5a, 32'h5a);
    tk(2);
    s_axi_rready <= 1'b1;
    tk(1);
    wr(8'h18, 8'h00);
    chk("bresp", 32'(tmr_pkg::RESP_SLVERR), 32'(tmr_pkg::RESP_SLVERR), 32'(resp));
    rd(8'h18);
    chk("rresp", 32'(tmr_pkg::RESP_SLVERR), 32'(tmr_pkg::RESP_SLVERR), 32'(resp));
    $display("test registers done");
    wr(tmr_pkg::ADDR_TIMER_SETUP, 8'h08);
    wr(tmr_pkg::ADDR_IRQ_CONTROL, 8'h20);
    sleep_i <= 1'b1;
    wr(tmr_pkg::ADDR_TICK_COUNT, 8'hfe);
    tk(100);
    rck(tmr_pkg::ADDR_TICK_COUNT, 32'hfe, 32'hfe);
    chk("timer_irq_o", 32'h0, 32'h0, 32'(timer_irq_o));
    sleep_i <= 1'b0;
    tk(40);
    chk("timer_irq_o", 32'h1, 32'h1, 32'(timer_irq_o));
    rck(tmr_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h1);
    wr(tmr_pkg::ADDR_IRQ_MASK, 8'h01);
    chk("irq_o", 32'h1, 32'h1, 32'(irq_o));
    wr(tmr_pkg::ADDR_IRQ_STATUS, 8'h01);
    chk("irq_o", 32'h0, 32'h0, 32'(irq_o));
    chk("timer_irq_o", 32'h1, 32'h1, 32'(timer_irq_o));
    wr(tmr_pkg::ADDR_IRQ_CONTROL, 8'h20);
    chk("timer_irq_o", 32'h0, 32'h0, 32'(timer_irq_o));
    wr(tmr_pkg::ADDR_IRQ_CONTROL, 8'h00);
    wr(tmr_pkg::ADDR_TICK_COUNT, 8'hfe);
    tk(40);
    rck(tmr_pkg::ADDR_IRQ_CONTROL, 32'h04, 32'h04);
    chk("timer_irq_o", 32'h0, 32'h0, 32'(timer_irq_o));
    $display("test overflow done");
    for (int r = 0; r < 3; r++) begin
      wclr();
      wr(tmr_pkg::ADDR_TIMER_SETUP, 8'(r));
      wr(tmr_pkg::ADDR_TICK_COUNT, 8'h00);
      tk(32 << (r + 1));
      rck(tmr_pkg::ADDR_TICK_COUNT, 32'h6, 32'h8);
    end
    wclr();
    wr(tmr_pkg::ADDR_TICK_COUNT, 8'h00);
    wr(tmr_pkg::ADDR_TIMER_SETUP, 8'h0a);
    wclr();
    wr(tmr_pkg::ADDR_TIMER_SETUP, 8'h0a);
    wr(tmr_pkg::ADDR_TICK_COUNT, 8'h00);
    tk(40);
    rck(tmr_pkg::ADDR_TICK_COUNT, 32'h7, 32'h9);
    s = nwt;
    bt(16);
    tk(4);
    chk("wdt ticks", 32'h4, 32'h4, 32'(nwt - s));
    s = nwt;
    bt(3);
    wclr();
    bt(3);
    tk(4);
    chk("wdt ticks", 32'h0, 32'h0, 32'(nwt - s));
    $display("test prescaler done");
    wr(tmr_pkg::ADDR_TIMER_SETUP, 8'h28);
    wr(tmr_pkg::ADDR_TICK_COUNT, 8'h00);
    tk(12);
    pg(8'h05);
    tk(12);
    rck(tmr_pkg::ADDR_TICK_COUNT, 32'h5, 32'h5);
    pidle <= 1'b1;
    tk(16);
    rck(tmr_pkg::ADDR_TICK_COUNT, 32'h6, 32'h6);
    wr(tmr_pkg::ADDR_TIMER_SETUP, 8'h38);
    wr(tmr_pkg::ADDR_TICK_COUNT, 8'h00);
    tk(12);
    pidle <= 1'b0;
    tk(16);
    rck(tmr_pkg::ADDR_TICK_COUNT, 32'h1, 32'h1);
    pidle <= 1'b1;
    tk(16);
    rck(tmr_pkg::ADDR_TICK_COUNT, 32'h1, 32'h1);
    wclr();
    wr(tmr_pkg::ADDR_TIMER_SETUP, 8'h30);
    wr(tmr_pkg::ADDR_TICK_COUNT, 8'h00);
    tk(12);
    pg(8'h06);
    tk(12);
    rck(tmr_pkg::ADDR_TICK_COUNT, 32'h3, 32'h3);
    $display("test counter done");
    finish_test();
  end
endmodule : test_eight_bit_timer_shared_prescaler
`default_nettype wire
